// [logic/adcc_regs.vh]
// register map, field positions and timing constants of the converter control
//
// Function
// [RULE_01] software picks a divider keeping the conversion clock below 80 MHz
// [RULE_02] the conversion clock stays strictly slower than the bus clock
// [RULE_03] common part is clocked whenever any converter clock enable is set
// [RULE_04] analog power follows only the power enable bit, not the clocks
// [RULE_05] ready rises after the start-up wait; no trigger before ready
// [RULE_06] resolution selectable as twelve, ten, eight or six bits
// [RULE_07] sampling time one of eight values, 2.5 up to 640.5 cycles
// [RULE_08] each input channel has its own sampling time
// [RULE_09] conversion starts by itself when the sampling interval ends
// [RULE_10] conversion lasts sample time plus bit count plus half a cycle
// [RULE_11] calibration only at twelve bits; resolution change waits for it
// [RULE_12] calibrate command computes, stores and applies the value itself
// [RULE_13] software may write the calibration value directly
// [RULE_14] init phase then calibrate phase; each status clears when done
// [RULE_15] after a resolution change ready is raised again before triggers
// [RULE_16] storing a calibration value sets no complete flag, no interrupt
// [RULE_17] software should prefer longer sampling times where it can
// [RULE_18] phase status bits read set from acceptance until phase completes
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// register byte addresses
`define ADCC_A_CTRL   8'h00
`define ADCC_A_STAT   8'h04
`define ADCC_A_MASK   8'h08
`define ADCC_A_SMPT   8'h0c
`define ADCC_A_CALV   8'h10
`define ADCC_A_DATA   8'h14
`define ADCC_A_CLKEN  8'h18

// control register fields
`define ADCC_C_PWR    0
`define ADCC_C_RES    2:1
`define ADCC_C_INIT   3
`define ADCC_C_CAL    4
`define ADCC_C_TRIG   5
`define ADCC_C_CHAN   7:6
`define ADCC_C_DIV    10:8

// status register fields
`define ADCC_S_RDY    0
`define ADCC_S_BUSY   1
`define ADCC_S_INIT   2
`define ADCC_S_CAL    3
`define ADCC_S_FLG    6:4

// sticky flag positions
`define ADCC_F_DONE   0
`define ADCC_F_RDY    1
`define ADCC_F_CAL    2

// resolution codes
`define ADCC_RES_12   2'h0
`define ADCC_RES_10   2'h1
`define ADCC_RES_8    2'h2
`define ADCC_RES_6    2'h3

// reset values
`define ADCC_DIV_RST  3'h1
`define ADCC_SMPT_RST 12'h000
`define ADCC_CALV_RST 7'h00

// timing
`define ADCC_CLK_MHZ     40
`define ADCC_STARTUP_NS  1000
`define ADCC_CALINIT_NS  2000
`define ADCC_READY_CYC   ((`ADCC_STARTUP_NS*`ADCC_CLK_MHZ+999)/1000)
`define ADCC_INIT_CYC    ((`ADCC_CALINIT_NS*`ADCC_CLK_MHZ+999)/1000)

`endif

// [logic/adcc_clk_div.v]
// divider making the conversion clock and its half-period ticks
module adcc_clk_div (
   core_clk,
   rst_b,
   run,
   div,
   halfTick,
   convClk
);
   input  wire       core_clk;
   input  wire       rst_b;
   input  wire       run;
   input  wire [2:0] div;
   output reg        halfTick;
   output reg        convClk;

   reg  [2:0] cnt_ff;
   wire [2:0] limit;

   // a zero divider is lifted to one so the clock is at most bus/4
   assign limit = (div == 3'h0) ? 3'h1 : div; // RULE_02

   // half period is limit+1 bus cycles; stops while not running
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff   <= 3'h0;
         halfTick <= 1'b0;
         convClk  <= 1'b0;
      end
      else if (!run)
      begin
         cnt_ff   <= 3'h0;
         halfTick <= 1'b0;
         convClk  <= 1'b0;
      end
      else if (cnt_ff == limit)
      begin
         cnt_ff   <= 3'h0;
         halfTick <= 1'b1;
         convClk  <= ~convClk;
      end
      else
      begin
         cnt_ff   <= cnt_ff + 3'h1;
         halfTick <= 1'b0;
      end
   end
endmodule

// [logic/adcc_ctrl.v]
// sar converter control: ready timing, sampling, conversion, calibration
`include "adcc_regs.vh"
module adcc_ctrl (
   core_clk,
   rst_b,
   addr,
   wrData,
   wrEn,
   rdEn,
   rdData,
   cmpIn,
   dacCode,
   chanSel,
   sampleHold,
   convActive,
   calMode,
   analogPowerEn,
   commonClkEn,
   convClk,
   irq
);
   input  wire        core_clk;
   input  wire        rst_b;
   input  wire [7:0]  addr;
   input  wire [31:0] wrData;
   input  wire        wrEn;
   input  wire        rdEn;
   output reg  [31:0] rdData;
   input  wire        cmpIn;
   output wire [11:0] dacCode;
   output reg  [1:0]  chanSel;
   output wire        sampleHold;
   output wire        convActive;
   output reg         calMode;
   output reg         analogPowerEn;
   output reg         commonClkEn;
   output wire        convClk;
   output reg         irq;

   // one-hot states
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_SMPL = 4'h2;
   localparam [3:0] S_CONV = 4'h4;
   localparam [3:0] S_INIT = 4'h8;
   localparam [31:0] READY_W  = `ADCC_READY_CYC;
   localparam [31:0] INIT_W   = `ADCC_INIT_CYC;
   localparam [7:0] READY_CNT = READY_W[7:0];
   localparam [6:0] INIT_CNT  = INIT_W[6:0];

   // resolution code to bit count
   function [3:0] resBits;
      input [1:0] res;
      begin
         case (res)
            `ADCC_RES_12: resBits = 4'd12;
            `ADCC_RES_10: resBits = 4'd10;
            `ADCC_RES_8:  resBits = 4'd8;
            default:      resBits = 4'd6;
         endcase
      end
   endfunction

   // sampling code to whole half cycles after the first tick (2.5 -> 5)
   function [10:0] smplHalf;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    smplHalf = 11'd5;
            3'h1:    smplHalf = 11'd13;
            3'h2:    smplHalf = 11'd25;
            3'h3:    smplHalf = 11'd49;
            3'h4:    smplHalf = 11'd95;
            3'h5:    smplHalf = 11'd185;
            3'h6:    smplHalf = 11'd495;
            default: smplHalf = 11'd1281;
         endcase
      end
   endfunction

   reg  [3:0]  state_ff;
   reg  [10:0] cnt_ff;
   reg  [11:0] sar_ff;
   reg  [11:0] trial_ff;
   reg  [3:0]  bits_ff;
   reg  [1:0]  res_ff;
   reg  [2:0]  div_ff;
   reg  [2:0]  clkEn_ff;
   reg  [11:0] smpt_ff;
   reg  [6:0]  calibration_value_ff;
   reg  [2:0]  mask_ff;
   reg  [2:0]  flag_ff;
   reg         ready_ff;
   reg  [7:0]  wait_ff;
   reg  [6:0]  init_ff;
   reg         initDone_ff;
   reg  [11:0] result_ff;
   reg  [3:0]  nxt_state;

   wire        halfTick;
   wire        wrCtrl;
   wire        resChg;
   wire        calBusy;
   wire        idle;
   wire        goTrig;
   wire        goInit;
   wire        goCal;
   wire        smplEnd;
   wire        convEnd;
   wire        decide;
   wire [2:0]  chSmpl;
   wire [11:0] keep;
   wire [11:0] corr;
   wire [2:0]  setFlg;
   wire [2:0]  clrFlg;

   adcc_clk_div u_div (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .run      (analogPowerEn),
      .div      (div_ff),
      .halfTick (halfTick),
      .convClk  (convClk)
   );

   // command decode from control writes
   assign wrCtrl  = wrEn && (addr == `ADCC_A_CTRL);
   assign idle    = state_ff[0];
   assign calBusy = state_ff[3] || (calMode && !idle);
   assign resChg  = wrCtrl && !calBusy &&
                    (wrData[`ADCC_C_RES] != res_ff); // RULE_11
   assign goTrig  = wrCtrl && wrData[`ADCC_C_TRIG] && ready_ff && idle &&
                    analogPowerEn && !resChg; // RULE_05
   assign goInit  = wrCtrl && wrData[`ADCC_C_INIT] && ready_ff && idle &&
                    analogPowerEn && (res_ff == `ADCC_RES_12) &&
                    !goTrig; // RULE_11
   assign goCal   = wrCtrl && wrData[`ADCC_C_CAL] && ready_ff && idle &&
                    analogPowerEn && (res_ff == `ADCC_RES_12) &&
                    initDone_ff && !goTrig && !goInit; // RULE_14

   // per-channel sampling time field
   assign chSmpl  = smpt_ff[chanSel*3 +: 3]; // RULE_08
   assign smplEnd = state_ff[1] && halfTick && (cnt_ff == 11'd0);
   assign convEnd = state_ff[2] && halfTick && (cnt_ff == 11'd0);
   assign decide  = state_ff[2] && halfTick && cnt_ff[0];

   // comparator decision keeps or drops the trial bit
   assign keep = cmpIn ? sar_ff : (sar_ff & ~trial_ff);

   // offset removal saturating at zero
   assign corr = (sar_ff > {5'h00, calibration_value_ff}) ?
                 (sar_ff - {5'h00, calibration_value_ff}) : 12'h000;

   assign dacCode    = sar_ff;
   assign sampleHold = state_ff[1];
   assign convActive = state_ff[2];

   // next state
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE:
            if (goTrig || goCal)
               nxt_state = S_SMPL;
            else if (goInit)
               nxt_state = S_INIT;
         S_SMPL:
            if (smplEnd)
               nxt_state = S_CONV; // RULE_09
         S_CONV:
            if (convEnd)
               nxt_state = S_IDLE;
         S_INIT:
            if (init_ff == INIT_CNT - 7'd1)
               nxt_state = S_IDLE;
         default:
            nxt_state = S_IDLE;
      endcase
      if (!analogPowerEn)
         nxt_state = S_IDLE;
   end

   // sequencer: sampling count, sar steps, calibration phases
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff    <= S_IDLE;
         cnt_ff      <= 11'd0;
         sar_ff      <= 12'h000;
         trial_ff    <= 12'h000;
         bits_ff     <= 4'd12;
         init_ff     <= 7'd0;
         initDone_ff <= 1'b0;
         calMode     <= 1'b0;
         result_ff   <= 12'h000;
      end
      else
      begin
         state_ff <= nxt_state;
         if (!analogPowerEn)
         begin
            calMode     <= 1'b0;
            initDone_ff <= 1'b0;
            init_ff     <= 7'd0;
         end
         else if (goTrig || goCal)
         begin
            cnt_ff   <= smplHalf(chSmpl); // RULE_07
            bits_ff  <= resBits(res_ff); // RULE_06
            calMode  <= goCal; // RULE_12
            sar_ff   <= 12'h800;
            trial_ff <= 12'h800;
         end
         else if (goInit)
         begin
            init_ff     <= 7'd0;
            initDone_ff <= 1'b0;
         end
         else if (state_ff[3])
         begin
            init_ff <= init_ff + 7'd1;
            if (init_ff == INIT_CNT - 7'd1)
               initDone_ff <= 1'b1; // RULE_14
         end
         else if (smplEnd)
         begin
            // 2*bits+1 half cycles of conversion
            cnt_ff <= {6'h00, bits_ff, 1'b0}; // RULE_10
         end
         else if (state_ff[1] && halfTick)
            cnt_ff <= cnt_ff - 11'd1;
         else if (convEnd)
         begin
            if (!calMode)
               result_ff <= corr >> (4'd12 - bits_ff); // RULE_13
            calMode <= 1'b0;
         end
         else if (state_ff[2] && halfTick)
         begin
            cnt_ff <= cnt_ff - 11'd1;
            if (decide)
            begin
               trial_ff <= trial_ff >> 1;
               sar_ff   <= keep | (trial_ff >> 1);
               if (cnt_ff == 11'd1)
                  sar_ff <= keep & ~(12'hfff >> bits_ff);
            end
         end
      end
   end

   // ready: start-up wait after power on or resolution change
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ready_ff <= 1'b0;
         wait_ff  <= 8'd0;
      end
      else if (!analogPowerEn || resChg)
      begin
         ready_ff <= 1'b0; // RULE_15
         wait_ff  <= 8'd0;
      end
      else if (!ready_ff)
      begin
         wait_ff <= wait_ff + 8'd1;
         if (wait_ff == READY_CNT - 8'd1)
            ready_ff <= 1'b1; // RULE_05
      end
   end

   // configuration registers
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         analogPowerEn <= 1'b0;
         res_ff        <= `ADCC_RES_12;
         chanSel       <= 2'h0;
         div_ff        <= `ADCC_DIV_RST;
         clkEn_ff      <= 3'h0;
         commonClkEn   <= 1'b0;
         smpt_ff       <= `ADCC_SMPT_RST;
         calibration_value_ff     <= `ADCC_CALV_RST;
         mask_ff       <= 3'h0;
      end
      else
      begin
         // common part runs when any converter clock is on
         commonClkEn <= |clkEn_ff; // RULE_03
         if (wrCtrl)
         begin
            analogPowerEn <= wrData[`ADCC_C_PWR]; // RULE_04
            if (resChg)
               res_ff <= wrData[`ADCC_C_RES];
            if (idle)
            begin
               chanSel <= wrData[`ADCC_C_CHAN];
               div_ff  <= wrData[`ADCC_C_DIV]; // RULE_01
            end
         end
         if (wrEn && addr == `ADCC_A_CLKEN)
            clkEn_ff <= wrData[2:0];
         if (wrEn && addr == `ADCC_A_SMPT)
            smpt_ff <= wrData[11:0];
         if (wrEn && addr == `ADCC_A_MASK)
            mask_ff <= wrData[2:0];
         // computed value wins over a same-cycle software write
         if (convEnd && calMode)
            calibration_value_ff <= (sar_ff > 12'h07f) ? 7'h7f : sar_ff[6:0]; // RULE_12
         else if (wrEn && addr == `ADCC_A_CALV && idle)
            calibration_value_ff <= wrData[6:0]; // RULE_13
      end
   end

   // sticky events; a calibration result raises only the cal flag
   assign setFlg[`ADCC_F_DONE] = convEnd && !calMode; // RULE_16
   assign setFlg[`ADCC_F_RDY]  = !ready_ff && analogPowerEn && !resChg &&
                                 (wait_ff == READY_CNT - 8'd1);
   assign setFlg[`ADCC_F_CAL]  = convEnd && calMode;
   assign clrFlg = (wrEn && addr == `ADCC_A_STAT) ?
                   wrData[`ADCC_S_FLG] : 3'h0;

   // flags with set over clear, and the masked interrupt
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         flag_ff <= 3'h0;
         irq     <= 1'b0;
      end
      else
      begin
         flag_ff <= (flag_ff & ~clrFlg) | setFlg;
         irq     <= |(((flag_ff & ~clrFlg) | setFlg) & mask_ff);
      end
   end

   // read port, data in the cycle after the strobe
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         rdData <= 32'h0000_0000;
      else if (rdEn)
      begin
         rdData <= 32'h0000_0000;
         case (addr)
            `ADCC_A_CTRL:
               rdData <= {21'h000000, div_ff, chanSel, 1'b0,
                          calMode && !idle, state_ff[3], // RULE_18
                          res_ff, analogPowerEn};
            `ADCC_A_STAT:
               rdData <= {25'h0000000, flag_ff, calMode && !idle,
                          state_ff[3], !idle, ready_ff};
            `ADCC_A_MASK:  rdData <= {29'h00000000, mask_ff};
            `ADCC_A_SMPT:  rdData <= {20'h00000, smpt_ff};
            `ADCC_A_CALV:  rdData <= {25'h0000000, calibration_value_ff};
            `ADCC_A_DATA:  rdData <= {20'h00000, result_ff};
            `ADCC_A_CLKEN: rdData <= {29'h00000000, clkEn_ff};
            default:       rdData <= 32'h0000_0000;
         endcase
      end
      else
         rdData <= 32'h0000_0000;
   end
endmodule

// [test/adcc_props.sv]
// port-level assertions for the converter control block
module adcc_props (
   input logic        core_clk,
   input logic        rst_b,
   input logic [7:0]  addr,
   input logic [31:0] wrData,
   input logic        wrEn,
   input logic        rdEn,
   input logic [31:0] rdData,
   input logic        sampleHold,
   input logic        convActive,
   input logic        analogPowerEn,
   input logic        commonClkEn,
   input logic        convClk,
   input logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   logic ctrlWr;
   logic enSeen_ff;

   // control register write strobe
   assign ctrlWr = wrEn && addr == 8'h00;

   // remember whether the latest clock enable write set any bit
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         enSeen_ff <= 1'b0;
      else if (wrEn && addr == 8'h18)
         enSeen_ff <= |wrData[2:0];
   end

   // enable write followed by two quiet cycles
   sequence s_enWr;
      wrEn && addr == 8'h18;
   endsequence
   sequence s_enQuiet;
      s_enWr ##1 (!(wrEn && addr == 8'h18))[*2];
   endsequence

   a_common_clk: assert property (
      s_enQuiet |-> commonClkEn == enSeen_ff)
      else $error("common clock enable differs from the enables");
   a_power_cause: assert property (
      $changed(analogPowerEn) |-> $past(ctrlWr) || $past(ctrlWr, 2))
      else $error("analog power moved without a control write");
   a_clk_stopped: assert property (
      !analogPowerEn && !$past(analogPowerEn) |=> !convClk)
      else $error("conversion clock runs while unpowered");
   a_sample_cause: assert property (
      $rose(sampleHold) |-> analogPowerEn && $past(ctrlWr))
      else $error("sampling began without a powered command");
   a_conv_follows: assert property (
      $fell(sampleHold) && analogPowerEn && !$past(ctrlWr)
      |-> ##[0:1] convActive)
      else $error("approximation did not follow sampling");
   a_phase_excl: assert property (
      !(sampleHold && convActive))
      else $error("sampling and approximation overlap");
   a_conv_min: assert property (
      $rose(convActive) |-> convActive[*8])
      else $error("approximation phase too short");
   a_read_idle: assert property (
      !$past(rdEn) |-> rdData == 32'h0)
      else $error("read data not zero outside the answer cycle");
   a_irq_masked: assert property (
      wrEn && addr == 8'h08 && wrData[2:0] == 3'h0
      ##1 !(wrEn && addr == 8'h08) |=> !irq)
      else $error("interrupt high with all sources masked");
endmodule

bind adcc_ctrl adcc_props u_props (
   .core_clk, .rst_b, .addr, .wrData, .wrEn, .rdEn, .rdData, .sampleHold,
   .convActive, .analogPowerEn, .commonClkEn, .convClk, .irq);

// [test/tb_top.sv]
// self-checking bench for the converter control block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wrData = 32'h0;
   logic        wrEn = 1'b0;
   logic        rdEn = 1'b0;
   logic [11:0] vin = 12'h0;
   logic [31:0] rdData, got, ctl, smpt;
   logic [11:0] dacCode;
   logic [1:0]  chanSel, ch;
   logic [6:0]  calv;
   logic        cmpIn, sampleHold, convActive, calMode;
   logic        analogPowerEn, commonClkEn, convClk, irq;
   int          d, bits;
   int          fail_count = 0;
   int          n_compared = 0;
   int          sht[8] = '{5, 13, 25, 49, 95, 185, 495, 1281};

   // clock and comparator of the analog side
   always #12.5 core_clk = ~core_clk;
   assign cmpIn = (vin >= dacCode);

   adcc_ctrl dut (.core_clk, .rst_b, .addr, .wrData, .wrEn, .rdEn,
      .rdData, .cmpIn, .dacCode, .chanSel, .sampleHold, .convActive,
      .calMode, .analogPowerEn, .commonClkEn, .convClk, .irq);

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] g);
      n_compared++;
      if (g !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, g);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] dat);
      addr <= a;
      wrData <= dat;
      wrEn <= 1'b1;
      @(posedge core_clk);
      wrEn <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(logic [7:0] a);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge core_clk);
      rdEn <= 1'b0;
      #1 got = rdData;
      @(posedge core_clk);
   endtask

   // read status until a bit reaches the wanted level, bounded
   task automatic poll(int b, logic v);
      int k = 0;
      rd(8'h04);
      while (got[b] !== v && k < 100)
      begin
         rd(8'h04);
         k++;
      end
      chk("statusBit", 32'(v), 32'(got[b]));
   endtask

   function automatic logic [31:0] expRes(logic [11:0] v, logic [6:0] c,
                                           int nb);
      logic [11:0] raw;
      raw = v & ~(12'hfff >> nb);
      raw = (raw > c) ? raw - c : 12'h0;
      return 32'(raw >> (12 - nb));
   endfunction

   // one triggered conversion with phase lengths, result and flag
   task automatic conv(int sh);
      int n = 0;
      int m = 0;
      int k = 0;
      int lo;
      int t = 0;
      logic c;
      lo = sh * (d + 1);
      wr(8'h00, ctl | 32'h20);
      #1;
      while (!sampleHold && k < 20)
      begin
         @(posedge core_clk);
         #1 k++;
      end
      while (sampleHold && n < 6000)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      c = convClk;
      while (convActive && m < 200)
      begin
         @(posedge core_clk);
         #1 m++;
         t += int'(convClk != c);
         c = convClk;
      end
      chk("chanSel", 32'(ch), 32'(chanSel));
      chk("sampleLen", 32'h1, 32'(n >= lo && n <= lo + d + 2));
      chk("convLen", (2 * bits + 1) * (d + 1), m);
      chk("convClkEdges", 2 * bits + 1, t);
      rd(8'h14);
      chk("result", expRes(vin, calv, bits), got);
      rd(8'h04);
      chk("doneFlag", 32'h1, 32'(got[4]));
      wr(8'h04, 32'h70);
   endtask

   // watchdog against a hang
   initial
   begin
      repeat (100000) @(posedge core_clk);
      fail_count++;
      test_done;
   end

   // main sequence
   initial
   begin
      void'($urandom(1));
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      for (int a = 0; a < 8; a++)
      begin
         rd(8'(4 * a));
         chk("resetVal", a == 0 ? 32'h100 : 32'h0, got);
      end
      wr(8'h00, 32'h101);
      wr(8'h00, 32'h121);
      #1 chk("earlyTrig", 32'h0, 32'(sampleHold));
      rd(8'h04);
      chk("notReady", 32'h0, 32'(got[0]));
      for (int i = 0; i < 8; i++)
      begin
         wr(8'h18, 32'(i));
         @(posedge core_clk);
         #1 chk("commonClk", 32'(i != 0), 32'(commonClkEn));
      end
      wr(8'h18, 32'h0);
      chk("powerOn", 32'h1, 32'(analogPowerEn));
      poll(0, 1'b1);
      // interrupt raised, masked, cleared
      wr(8'h08, 32'h2);
      #1 chk("irqOn", 32'h1, 32'(irq));
      wr(8'h08, 32'h0);
      #1 chk("irqMasked", 32'h0, 32'(irq));
      wr(8'h08, 32'h2);
      wr(8'h04, 32'h70);
      #1 chk("irqCleared", 32'h0, 32'(irq));
      wr(8'h08, 32'h0);
      // calibration: init phase, then compute phase
      wr(8'h00, 32'h109);
      rd(8'h04);
      chk("initBusy", 32'h1, 32'(got[2]));
      wr(8'h00, 32'h107);
      rd(8'h00);
      chk("resHeld", 32'h0, 32'(got[2:1]));
      poll(2, 1'b0);
      wr(8'h0c, 32'h2);
      vin <= 12'($urandom);
      wr(8'h00, 32'h111);
      #1 chk("calMode", 32'h1, 32'(calMode));
      rd(8'h04);
      chk("calBusy", 32'h1, 32'(got[3]));
      poll(3, 1'b0);
      chk("calModeOff", 32'h0, 32'(calMode));
      calv = (vin > 12'h7f) ? 7'h7f : vin[6:0];
      rd(8'h10);
      chk("calValue", 32'(calv), got);
      rd(8'h04);
      chk("calFlags", 32'h4, 32'(got[6:4]));
      rd(8'h14);
      chk("dataKept", 32'h0, got);
      wr(8'h04, 32'h70);
      calv = 7'($urandom);
      wr(8'h10, 32'(calv));
      rd(8'h04);
      chk("noDone", 32'h0, 32'(got[4]));
      // every sample code and resolution on random channels
      for (int i = 0; i < 8; i++)
      begin
         ch = 2'($urandom);
         d = 1 + $urandom % 3;
         bits = 12 - 2 * (i % 4);
         smpt = $urandom;
         smpt[3 * ch +: 3] = 3'(i);
         vin <= 12'($urandom);
         ctl = (d << 8) | (ch << 6) | ((i % 4) << 1) | 1;
         wr(8'h0c, smpt);
         wr(8'h00, ctl);
         if (i > 0)
         begin
            wr(8'h00, ctl | 32'h20);
            #1 chk("trigAfterRes", 32'h0, 32'(sampleHold));
         end
         poll(0, 1'b1);
         conv(sht[i]);
      end
      wr(8'h00, ctl | 32'h8);
      rd(8'h04);
      chk("initRefused", 32'h0, 32'(got[2]));
      // power off stops the conversion clock
      wr(8'h00, 32'h0);
      repeat (2) @(posedge core_clk);
      #1 chk("clkStopped", 32'h0, 32'(convClk));
      chk("powerOff", 32'h0, 32'(analogPowerEn));
      test_done;
   end
endmodule
